//--- core/fpe_defs.svh
// Purpose: offsets, field positions and reset values of the flash sequencer
// Assumes: cpu addresses are 16 bits, apb byte address is four times the index
// Notes: definitions only
`ifndef FPE_DEFS_SVH
`define FPE_DEFS_SVH

// ----------------------------------------------------------------
// register indices (cpu addresses), byte address = 4 * index
// ----------------------------------------------------------------
`define FPE_IDX_CTL 16'hfe08
`define FPE_IDX_STAT 16'hfe0a
`define FPE_IDX_BPR 16'hff81
`define FPE_ARR_TOP 16'h7fff

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define FPE_CTL_PGM 0
`define FPE_CTL_ERASE 1
`define FPE_CTL_MASS 2
`define FPE_CTL_HIGH_VOLTAGE_ENABLE 3

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define FPE_ST_FAIL 0
`define FPE_ST_REFUSED 1
`define FPE_ST_WIPING 2
`define FPE_ST_STANDBY 3
`define FPE_ST_SEQ_LO 4

// ----------------------------------------------------------------
// geometry and reset values
// ----------------------------------------------------------------
`define FPE_ROW_BITS 6
`define FPE_PAGE_BITS 7
`define FPE_ERASED_BYTE 8'hff
`define FPE_NO_PROTECT 8'hff
`define FPE_CTL_RST 4'h0

`endif

//--- core/fpe_pkg.sv
// Purpose: types and shared decode functions of the flash sequencer
// Assumes: array occupies cpu addresses 0x0000 to 0x7fff
// Notes: offsets live in fpe_defs.svh
`include "fpe_defs.svh"

package fpe_pkg;

    typedef enum logic [2:0] {
        FPE_SEQ_IDLE = 3'b000,
        FPE_SEQ_SELECTED = 3'b001,
        FPE_SEQ_CHECKED = 3'b010,
        FPE_SEQ_LATCHED = 3'b011,
        FPE_SEQ_HV = 3'b100
    } fpe_seq_t;

    // address falls inside the array
    function automatic logic fpe_in_array(input logic [15:0] a);
        fpe_in_array = (a <= `FPE_ARR_TOP);
    endfunction

    // protected from {bpr,7'b0} to top; 0xff means no protection
    function automatic logic fpe_is_protected(input logic [14:0] a, input logic [7:0] bpr);
        fpe_is_protected = (bpr != `FPE_NO_PROTECT) && (a >= {bpr, 7'h00});
    endfunction

    // same 64-byte row
    function automatic logic fpe_same_row(input logic [14:0] a, input logic [14:0] b);
        fpe_same_row = (a[14:`FPE_ROW_BITS] == b[14:`FPE_ROW_BITS]);
    endfunction

endpackage

//--- core/fpe_sync2.sv
// Purpose: two-flop synchroniser for the low-power request pins
// Assumes: inputs are asynchronous levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps

module fpe_sync2
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] d,
    output logic [1:0] q
);
    logic [1:0] meta_r;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= 2'h0;
            q <= 2'h0;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

//--- core/fpe_array_mem.sv
// Purpose: byte array of the second flash, registered read port
// Assumes: one write per cycle; contents are not reset
// Notes: and-write models programming, bits only go from one to zero
`timescale 1ns/1ps

module fpe_array_mem
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic wr_and,
    input wire logic [14:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [14:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:32767];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            if (wr_and)
                mem[wr_addr] <= mem[wr_addr] & wr_data;
            else
                mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rd_data <= 8'h00;
        else
            rd_data <= mem[rd_addr];
    end
endmodule

//--- core/fpe_top.sv
// Purpose: program, page wipe and standby control of the second flash array
// Assumes: apb3 slave, cpu index = paddr[17:2], clk 50 MHz
// Notes: timing waits are software's; hardware enforces order and interlocks
//
// Summary of operation
// - a page wipe sets all 128 bytes of the latched page to ones.
// - a row is 64 bytes aligned on 0x00, 0x40, 0x80 or 0xc0.
// - program writes outside the latched row fail the programming cycle.
// - with one select set and the protect byte read, the next array write latches address and data.
// - wait or stop aborts program or wipe and puts the array in standby.
// - wait or stop in read mode leaves the array untouched.
// - in standby every array control signal is inactive.
// - erased bits read one, programmed bits read zero.
// - pages hold two 64-byte rows; wipe by page, program by row.
// - control decodes at 0xfe08, protect byte at 0xff81.
// - high voltage enable sets only with a select and proper order.
// - mass select one wipes whole array, zero wipes one page.
// - erase and program select are never both one.
// - a protected latched address refuses high voltage enable.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "fpe_defs.svh"

module fpe_top
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] protect_value,
    input wire logic cpu_wait_req,
    input wire logic cpu_stop_req,
    output logic pump_on,
    output logic array_erase_en,
    output logic array_program_en,
    output logic array_mass_en,
    output logic array_standby
);
    import fpe_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic pgm_r;
    logic erase_r;
    logic mass_r;
    logic high_voltage_enable_r;
    fpe_seq_t seq_r;
    logic [14:0] lat_addr_r;
    logic [7:0] lat_data_r;
    logic [14:0] prog_addr_r;
    logic prog_pend_r;
    logic row_fail_r;
    logic fail_r;
    logic refused_r;
    logic wiping_r;
    logic [14:0] wipe_addr_r;
    logic [14:0] wipe_last_r;
    logic [1:0] lp_s;
    logic lp;
    logic [7:0] mem_rd;
    logic [15:0] idx;
    logic access;
    logic done;
    logic aligned;
    logic hit_ctl;
    logic hit_stat;
    logic hit_bpr;
    logic hit_arr;
    logic wr_ctl;
    logic wr_stat;
    logic wr_arr;
    logic rd_bpr;
    logic hv_allowed;
    logic hv_set;
    logic prog_wr;
    logic prog_bad;
    logic mem_wr_en;
    logic mem_wr_and;
    logic [14:0] mem_wr_addr;
    logic [7:0] mem_wr_data;
    logic [7:0] ctl_view;
    logic [7:0] stat_view;
    logic [7:0] rd_mux;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign idx = paddr[17:2];
    assign access = psel & penable;
    assign done = access & pready;
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_ctl = aligned && (idx == `FPE_IDX_CTL);
    assign hit_bpr = aligned && (idx == `FPE_IDX_BPR);
    assign hit_stat = aligned && (idx == `FPE_IDX_STAT);
    assign hit_arr = aligned && fpe_in_array(idx);
    assign wr_ctl = done & pwrite & hit_ctl;
    assign wr_stat = done & pwrite & hit_stat;
    assign wr_arr = done & pwrite & hit_arr;
    assign rd_bpr = done & ~pwrite & hit_bpr;

    assign ctl_view = {4'h0, high_voltage_enable_r, mass_r, erase_r, pgm_r};
    assign stat_view = {1'b0, seq_r, array_standby, wiping_r, refused_r, fail_r};

    always_comb
    begin
        rd_mux = 8'h00;
        if (hit_ctl)
            rd_mux = ctl_view;
        else if (hit_stat)
            rd_mux = stat_view;
        else if (hit_bpr)
            rd_mux = protect_value;
        else if (hit_arr)
            rd_mux = mem_rd;
    end

    // ----------------------------------------------------------------
    // apb answer, one wait state
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access & ~pready;
            if (access & ~pready)
            begin
                prdata <= {24'h00_0000, rd_mux};
                pslverr <= ~(hit_ctl | hit_stat | hit_bpr | hit_arr);
            end
        end
    end

    // ----------------------------------------------------------------
    // low power requests
    // ----------------------------------------------------------------
    fpe_sync2 u_sync
    (
        .clk(clk),
        .rstn(rstn),
        .d({cpu_stop_req, cpu_wait_req}),
        .q(lp_s)
    );
    assign lp = |lp_s;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    // select, order and standby gate
    assign hv_allowed = (seq_r == FPE_SEQ_LATCHED) && (pgm_r ^ erase_r) && !lp
                        && !fpe_is_protected(lat_addr_r, protect_value);
    assign hv_set = wr_ctl && pwdata[`FPE_CTL_HIGH_VOLTAGE_ENABLE] && !high_voltage_enable_r && hv_allowed;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pgm_r <= 1'b0;
            erase_r <= 1'b0;
            mass_r <= 1'b0;
        end
        else if (wr_ctl)
        begin
            mass_r <= pwdata[`FPE_CTL_MASS];
            if (!(pwdata[`FPE_CTL_PGM] && pwdata[`FPE_CTL_ERASE]))
            begin
                pgm_r <= pwdata[`FPE_CTL_PGM];
                erase_r <= pwdata[`FPE_CTL_ERASE];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            high_voltage_enable_r <= 1'b0;
        else if (lp)
            high_voltage_enable_r <= 1'b0;
        else if (wr_ctl)
            high_voltage_enable_r <= pwdata[`FPE_CTL_HIGH_VOLTAGE_ENABLE] && (high_voltage_enable_r || hv_allowed);
    end

    // ----------------------------------------------------------------
    // sequence tracking
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            seq_r <= FPE_SEQ_IDLE;
        else if (!pgm_r && !erase_r && !high_voltage_enable_r)
            seq_r <= FPE_SEQ_IDLE;
        else
        begin
            case (seq_r)
                FPE_SEQ_IDLE:
                    seq_r <= FPE_SEQ_SELECTED;
                FPE_SEQ_SELECTED:
                    if (rd_bpr)
                        seq_r <= FPE_SEQ_CHECKED;
                FPE_SEQ_CHECKED:
                    if (wr_arr)
                        seq_r <= FPE_SEQ_LATCHED;
                FPE_SEQ_LATCHED:
                    if (hv_set)
                        seq_r <= FPE_SEQ_HV;
                FPE_SEQ_HV:
                    if (!high_voltage_enable_r)
                        seq_r <= FPE_SEQ_LATCHED;
                default:
                    seq_r <= FPE_SEQ_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // address and data latch
    // ----------------------------------------------------------------
    // writes count only inside a select sequence
    assign prog_wr = wr_arr && (seq_r == FPE_SEQ_HV) && pgm_r && high_voltage_enable_r;
    assign prog_bad = prog_wr && (row_fail_r || !fpe_same_row(idx[14:0], lat_addr_r));

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lat_addr_r <= 15'h0000;
            lat_data_r <= 8'h00;
            prog_addr_r <= 15'h0000;
            prog_pend_r <= 1'b0;
        end
        else
        begin
            prog_pend_r <= prog_wr && !prog_bad && !lp;
            if (wr_arr && (seq_r == FPE_SEQ_CHECKED))
            begin
                lat_addr_r <= idx[14:0];
                lat_data_r <= pwdata[7:0];
            end
            else if (prog_wr)
            begin
                prog_addr_r <= idx[14:0];
                lat_data_r <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // failure and refusal flags, set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            row_fail_r <= 1'b0;
            fail_r <= 1'b0;
            refused_r <= 1'b0;
        end
        else
        begin
            // whole cycle fails once a row is crossed
            if (prog_bad)
                row_fail_r <= 1'b1;
            else if (seq_r != FPE_SEQ_HV)
                row_fail_r <= 1'b0;
            if (prog_bad)
                fail_r <= 1'b1;
            else if (wr_stat && pwdata[`FPE_ST_FAIL])
                fail_r <= 1'b0;
            if (wr_ctl && pwdata[`FPE_CTL_HIGH_VOLTAGE_ENABLE] && !high_voltage_enable_r && !hv_allowed)
                refused_r <= 1'b1;
            else if (wr_stat && pwdata[`FPE_ST_REFUSED])
                refused_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // wipe engine
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wiping_r <= 1'b0;
            wipe_addr_r <= 15'h0000;
            wipe_last_r <= 15'h0000;
        end
        else if (lp || !high_voltage_enable_r && !hv_set)
            wiping_r <= 1'b0;
        else if (hv_set && erase_r)
        begin
            wiping_r <= 1'b1;
            if (mass_r)
            begin
                wipe_addr_r <= 15'h0000;
                wipe_last_r <= 15'h7fff;
            end
            else
            begin
                wipe_addr_r <= {lat_addr_r[14:`FPE_PAGE_BITS], 7'h00};
                wipe_last_r <= {lat_addr_r[14:`FPE_PAGE_BITS], 7'h7f};
            end
        end
        else if (wiping_r)
        begin
            if (wipe_addr_r == wipe_last_r)
                wiping_r <= 1'b0;
            wipe_addr_r <= wipe_addr_r + 15'h0001;
        end
    end

    // ----------------------------------------------------------------
    // array write port
    // ----------------------------------------------------------------
    // wipe writes ones, program only clears bits
    assign mem_wr_en = wiping_r | prog_pend_r;
    assign mem_wr_and = ~wiping_r;
    assign mem_wr_addr = wiping_r ? wipe_addr_r : prog_addr_r;
    assign mem_wr_data = wiping_r ? `FPE_ERASED_BYTE : lat_data_r;

    fpe_array_mem u_mem
    (
        .clk(clk),
        .rstn(rstn),
        .wr_en(mem_wr_en),
        .wr_and(mem_wr_and),
        .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data),
        .rd_addr(idx[14:0]),
        .rd_data(mem_rd)
    );

    // ----------------------------------------------------------------
    // array control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pump_on <= 1'b0;
            array_erase_en <= 1'b0;
            array_program_en <= 1'b0;
            array_mass_en <= 1'b0;
            array_standby <= 1'b0;
        end
        else
        begin
            // read mode only shows standby level
            array_standby <= lp;
            pump_on <= high_voltage_enable_r & ~lp;
            array_erase_en <= erase_r & ~lp;
            array_program_en <= pgm_r & ~lp;
            array_mass_en <= erase_r & mass_r & ~lp;
        end
    end

endmodule

//--- verif/fpe_top_asserts.sv
// Purpose: port-level checks of the flash sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to fpe_top below
`timescale 1ns/1ps

module fpe_top_asserts
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] protect_value,
    input wire logic cpu_wait_req,
    input wire logic cpu_stop_req,
    input wire logic pump_on,
    input wire logic array_erase_en,
    input wire logic array_program_en,
    input wire logic array_mass_en,
    input wire logic array_standby
);
    logic done;
    logic hv_wr;
    logic bpr_rd;
    logic unmapped;
    logic low_req;

    assign done = psel && penable && pready && paddr[1:0] == 2'b00;
    assign hv_wr = done && pwrite && paddr[17:2] == 16'hfe08 && pwdata[3];
    assign bpr_rd = done && !pwrite && paddr[17:2] == 16'hff81;
    assign unmapped = paddr[17:2] > 16'h7fff && paddr[17:2] != 16'hfe08 && paddr[17:2] != 16'hfe0a
        && paddr[17:2] != 16'hff81;
    assign low_req = cpu_wait_req || cpu_stop_req;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ----
    // low-power request held through the synchroniser
    // ----
    sequence s_low_held;
        low_req [*3];
    endsequence
    sequence s_awake_held;
        !low_req [*3];
    endsequence

    a_select_interlock:
        assert property (!(array_erase_en && array_program_en))
        else $error("erase and program enables high together");
    a_hv_needs_select:
        assert property ($rose(pump_on) |-> (array_erase_en ^ array_program_en) && ($past(hv_wr, 1) || $past(hv_wr, 2)))
        else $error("pump on without single select or control write");
    a_lowpower_enter:
        assert property (s_low_held |=> array_standby)
        else $error("standby missing after low-power request");
    a_lowpower_exit:
        assert property (s_awake_held |=> !array_standby)
        else $error("standby without low-power request");
    a_standby_quiet:
        assert property (array_standby && $past(array_standby) |-> !(pump_on || array_erase_en || array_program_en
            || array_mass_en))
        else $error("array control active in standby");
    a_mass_with_erase:
        assert property (array_mass_en |-> array_erase_en)
        else $error("mass enable without erase enable");
    a_protect_read:
        assert property (bpr_rd |-> prdata == {24'h0, $past(protect_value)})
        else $error("protect byte read wrong");
    a_unmapped_err:
        assert property (done && unmapped |-> pslverr)
        else $error("unmapped access without error");
endmodule

bind fpe_top fpe_top_asserts fpe_top_asserts_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .protect_value(protect_value), .cpu_wait_req(cpu_wait_req), .cpu_stop_req(cpu_stop_req), .pump_on(pump_on),
    .array_erase_en(array_erase_en), .array_program_en(array_program_en), .array_mass_en(array_mass_en),
    .array_standby(array_standby));

//--- verif/fpe_top_tb.sv
// Purpose: self-checking bench of the flash sequencer over apb
// Assumes: pready answers within a few cycles
// Notes: array contents unknown until wiped
`timescale 1ns/1ps

module fpe_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] protect_value = 8'hff;
    logic cpu_wait_req = 1'b0;
    logic cpu_stop_req = 1'b0;
    logic pump_on;
    logic array_erase_en;
    logic array_program_en;
    logic array_mass_en;
    logic array_standby;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int total_checks = 0;

    fpe_top fpe_top_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .protect_value(protect_value), .cpu_wait_req(cpu_wait_req), .cpu_stop_req(cpu_stop_req),
        .pump_on(pump_on), .array_erase_en(array_erase_en), .array_program_en(array_program_en),
        .array_mass_en(array_mass_en), .array_standby(array_standby));

    initial
    begin
        forever #10 clk = ~clk;
    end

    // ----
    // reporting and bus tasks
    // ----
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic give_up;
        n_mismatch++;
        wrap_up();
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] data);
        int n;
        n = 0;
        // setup phase starts on a rising edge
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, data};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
                give_up();
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        settle(1);
    endtask

    task automatic rd_check(input string what, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(what, exp, rd);
    endtask

    // ----
    // scenarios
    // ----
    task automatic t_regs;
        rd_check("control reset", 16'hfe08, 32'h0);
        rd_check("status reset", 16'hfe0a, 32'h0);
        apb(1'b1, 16'hff81, 8'h00);
        rd_check("protect byte", 16'hff81, 32'hff);
        apb(1'b0, 16'hfe0c, 8'h00);
        check("unmapped error", 32'h1, {31'h0, err});
        $display("test regs done");
    endtask

    task automatic wipe(input logic [15:0] a);
        int n;
        n = 0;
        apb(1'b1, 16'hfe08, 8'h02);
        apb(1'b0, 16'hff81, 8'h00);
        apb(1'b1, a, 8'h55);
        apb(1'b1, 16'hfe08, 8'h0a);
        check("wipe outputs", 32'h6, {29'h0, pump_on, array_erase_en, array_mass_en});
        apb(1'b0, 16'hfe0a, 8'h00);
        while (rd[2] !== 1'b0)
        begin
            n++;
            if (n > 100)
                give_up();
            apb(1'b0, 16'hfe0a, 8'h00);
        end
        apb(1'b1, 16'hfe08, 8'h08);
        apb(1'b1, 16'hfe08, 8'h00);
        for (int i = 0; i < 128; i++)
            rd_check("wiped byte", (a & 16'hff80) + 16'(i), 32'hff);
        $display("test wipe done");
    endtask

    task automatic t_program;
        wipe(16'h1340);
        apb(1'b1, 16'hfe08, 8'h01);
        apb(1'b0, 16'hff81, 8'h00);
        apb(1'b1, 16'h1340, 8'hff);
        apb(1'b1, 16'hfe08, 8'h09);
        check("program outputs", 32'h3, {30'h0, pump_on, array_program_en});
        apb(1'b1, 16'h1340, 8'ha5);
        apb(1'b1, 16'h137f, 8'h3c);
        apb(1'b1, 16'h1300, 8'h00);
        apb(1'b0, 16'hfe0a, 8'h00);
        check("row fail flag", 32'h1, rd & 32'h1);
        apb(1'b1, 16'hfe08, 8'h08);
        apb(1'b1, 16'hfe08, 8'h00);
        rd_check("row first byte", 16'h1340, 32'ha5);
        rd_check("row last byte", 16'h137f, 32'h3c);
        rd_check("untouched byte", 16'h1341, 32'hff);
        rd_check("other row byte", 16'h1300, 32'hff);
        apb(1'b1, 16'hfe0a, 8'h01);
        rd_check("status cleared", 16'hfe0a, 32'h0);
        $display("test program done");
    endtask

    task automatic t_interlock;
        apb(1'b1, 16'hfe08, 8'h03);
        rd_check("both selects", 16'hfe08, 32'h0);
        apb(1'b1, 16'hfe08, 8'h02);
        apb(1'b1, 16'hfe08, 8'h01);
        rd_check("select swap", 16'hfe08, 32'h1);
        apb(1'b1, 16'hfe08, 8'h09);
        rd_check("early hv", 16'hfe08, 32'h1);
        apb(1'b0, 16'hfe0a, 8'h00);
        check("refused flag", 32'h2, rd & 32'h2);
        apb(1'b1, 16'hfe08, 8'h00);
        apb(1'b1, 16'hfe0a, 8'h02);
        apb(1'b1, 16'h1341, 8'h00);
        rd_check("unselected write", 16'h1341, 32'hff);
        apb(1'b1, 16'hfe08, 8'h06);
        settle(2);
        check("mass outputs", 32'h3, {30'h0, array_erase_en, array_mass_en});
        apb(1'b1, 16'hfe08, 8'h00);
        $display("test interlock done");
    endtask

    task automatic t_protect;
        @(posedge clk);
        protect_value <= 8'h26;
        apb(1'b1, 16'hfe08, 8'h02);
        rd_check("protect value", 16'hff81, 32'h26);
        apb(1'b1, 16'h1340, 8'h00);
        apb(1'b1, 16'hfe08, 8'h0a);
        settle(2);
        check("protected pump", 32'h0, {31'h0, pump_on});
        rd_check("protected hv", 16'hfe08, 32'h2);
        apb(1'b1, 16'hfe08, 8'h00);
        apb(1'b1, 16'hfe0a, 8'h02);
        @(posedge clk);
        protect_value <= 8'hff;
        $display("test protect done");
    endtask

    task automatic t_standby;
        apb(1'b1, 16'hfe08, 8'h02);
        apb(1'b0, 16'hff81, 8'h00);
        apb(1'b1, 16'h1200, 8'h00);
        apb(1'b1, 16'hfe08, 8'h0a);
        @(posedge clk);
        cpu_stop_req <= 1'b1;
        settle(5);
        check("standby outputs", 32'h4, {29'h0, array_standby, pump_on, array_erase_en});
        rd_check("standby status", 16'hfe0a, 32'h38);
        @(posedge clk);
        cpu_stop_req <= 1'b0;
        settle(5);
        rd_check("after stop", 16'hfe08, 32'h2);
        apb(1'b1, 16'hfe08, 8'h00);
        @(posedge clk);
        cpu_wait_req <= 1'b1;
        settle(5);
        check("wait standby", 32'h1, {31'h0, array_standby});
        @(posedge clk);
        cpu_wait_req <= 1'b0;
        settle(5);
        rd_check("read after wait", 16'h1340, 32'ha5);
        $display("test standby done");
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        settle(1);
        t_regs();
        t_program();
        t_interlock();
        t_protect();
        t_standby();
        wrap_up();
    end
endmodule
